// [src/sfp_pkg.sv]
package sfp_pkg;
    localparam int CLK_MHZ = 100;
    // opcodes
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    // status byte fields
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_BP_LO = 2;
    localparam int ST_QE = 6;
    localparam int ST_STATUS_WRITE_DISABLE_BIT = 7;
    // config byte fields
    localparam int CF_ODS = 0;
    localparam int CF_TB = 3;
    localparam int CF_DC = 6;
    // reset values
    localparam logic [3:0] RST_BP = 4'h0;
    localparam logic RST_QE = 1'b0;
    localparam logic RST_STATUS_WRITE_DISABLE_BIT = 1'b0;
    localparam logic RST_ODS = 1'b0;
    localparam logic RST_TB = 1'b0;
    localparam logic RST_DC = 1'b0;
    // dummy cycle counts per dummy_cycle_select
    localparam logic [3:0] DUAL_DUMMY_0 = 4'h4;
    localparam logic [3:0] DUAL_DUMMY_1 = 4'h8;
    localparam logic [3:0] QUAD_DUMMY_0 = 4'h6;
    localparam logic [3:0] QUAD_DUMMY_1 = 4'hA;
    // self-timed cycles
    localparam int STATUS_WRITE_CYCLE_TIME_NS = 2000;
    localparam int STATUS_WRITE_CYCLES = (STATUS_WRITE_CYCLE_TIME_NS * CLK_MHZ) / 1000;
    localparam int PROGRAM_ERASE_TIME_NS = 3000;
    localparam int PROGRAM_ERASE_CYCLES = (PROGRAM_ERASE_TIME_NS * CLK_MHZ) / 1000;
    // controller register map (byte addresses)
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_TXDATA = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam logic [3:0] REG_PINS = 4'hC;
    localparam int CMD_NTX_LO = 8;
    localparam int CMD_RX = 11;
    localparam int SCLK_HALF_CYCLES = 8;
    typedef enum logic [1:0] {SFP_IDLE = 2'b00, SFP_RUN = 2'b01, SFP_END = 2'b11} sfp_host_state_t;
endpackage

// [src/sfp_link_if.sv]
`timescale 1ns/10ps
interface sfp_link_if;
    logic sclk;
    logic cs_n;
    logic [3:0] h_io_o;
    logic [3:0] h_io_oe_n;
    logic [3:0] d_io_o;
    logic [3:0] d_io_oe_n;
    logic [3:0] io;
    // wire level: host wins, then device, else pulled up
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            io[i] = !h_io_oe_n[i] ? h_io_o[i] : (!d_io_oe_n[i] ? d_io_o[i] : 1'b1);
        end
    end
    modport host (output sclk, output cs_n, output h_io_o, output h_io_oe_n, input io);
    modport device (input sclk, input cs_n, input io, output d_io_o, output d_io_oe_n);
endinterface

// [src/sfp_flash_dev.sv]
// Functional notes
// - config readable anytime, even while busy
// - config byte out on io1, upper lines ignored
// - status bit0 is volatile busy flag
// - write-enable latch; program/erase ignored when clear
// - latch clears at completion or protected target
// - block-protect bits; chip erase only when zero
// - quad enable bit repurposes wp/hold pins
// - quad mode disables hardware protection and hold
// - write-disable plus wp low refuses status write
// - config bit0 output strength, volatile
// - config bit3 one-time top/bottom select
// - config bit6 selects dummy cycle counts
// - host sends write enable before status write
// - status write never touches bits 1,0
// - status write aborted off byte boundary
// - status write self-timed, busy, then clears latch
// - outside hardware protection, protect bits writable
// - hardware protection freezes top/bottom, guards region
// - host polls busy before next command
// - opcode 06 framed by chip select sets latch
// - read status 05 streams continuously, anytime
// - hardware protection ends with wp high or quad enable set
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
module sfp_flash_dev #(
    parameter logic [7:0] READ_CONFIG_OP = 8'hA5,
    parameter logic [7:0] PAGE_PROGRAM_OP = 8'h02,
    parameter logic [7:0] SECTOR_ERASE_OP = 8'h20,
    parameter logic [7:0] BLOCK_ERASE_OP = 8'hD8,
    parameter logic [7:0] CHIP_ERASE_OP = 8'hC7,
    parameter int TW_CYCLES = sfp_pkg::STATUS_WRITE_CYCLES,
    parameter int PE_CYCLES = sfp_pkg::PROGRAM_ERASE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    sfp_link_if.device link,
    output logic busy_o,
    output logic [7:0] status_o,
    output logic [7:0] config_o,
    output logic quad_mode_o,
    output logic hw_protect_o,
    output logic quarter_strength_o,
    output logic [3:0] dual_dummy_o,
    output logic [3:0] quad_dummy_o
);
    import sfp_pkg::*;

    // the busy timer is 16 bits wide
    if (TW_CYCLES < 1 || TW_CYCLES > 65535 || PE_CYCLES < 1 || PE_CYCLES > 65535) begin : g_bad_cycles
        $error("sfp_flash_dev: cycle counts must be 1..65535");
    end

    typedef struct packed {
        logic [1:0] sclk_s;
        logic sclk_q;
        logic [1:0] cs_s;
        logic cs_q;
        logic [1:0] si_s;
        logic [1:0] wp_s;
        logic [7:0] opc;
        logic [5:0] cnt;
        logic [23:0] sh;
        logic [23:0] addr;
        logic so;
        logic so_en;
        logic [3:0] bp;
        logic qe;
        logic status_write_disable_bit;
        logic write_enable_latch;
        logic output_strength_select;
        logic tb;
        logic dc;
        logic busy;
        logic [15:0] tmr;
    } sfp_dev_st_t;

    sfp_dev_st_t st_ff;
    sfp_dev_st_t nxt_st;

    localparam logic [15:0] TW_LOAD = 16'(TW_CYCLES - 1);
    localparam logic [15:0] PE_LOAD = 16'(PE_CYCLES - 1);

    // counts bits in the frame; past 63 it falls back to 56, keeping the byte phase
    function automatic logic [5:0] sat_inc(input logic [5:0] c);
        sat_inc = (c == 6'h3F) ? 6'h38 : c + 6'h01;
    endfunction

    // linear sixteenths from the top (tb=0) or bottom (tb=1)
    function automatic logic in_protected(input logic [23:0] a, input logic [3:0] bp, input logic tb);
        logic [3:0] slice;
        slice = tb ? a[23:20] : (4'hF - a[23:20]);
        in_protected = (bp != 4'h0) && (slice < bp);
    endfunction

    logic [7:0] status_byte;
    logic [7:0] config_byte;
    logic wp_level;
    logic hardware_protected_mode;
    logic rise;
    logic fall;
    logic cs_rise;
    logic [23:0] tgt;

    always_comb begin
        status_byte = {st_ff.status_write_disable_bit, st_ff.qe, st_ff.bp, st_ff.write_enable_latch, st_ff.busy};
        config_byte = 8'h00;
        config_byte[CF_ODS] = st_ff.output_strength_select;
        config_byte[CF_TB] = st_ff.tb;
        config_byte[CF_DC] = st_ff.dc;
        // with quad on the pin is data, so protection reads as released
        wp_level = st_ff.qe | st_ff.wp_s[1];
        hardware_protected_mode = st_ff.status_write_disable_bit & ~wp_level;
        rise = !st_ff.sclk_q && st_ff.sclk_s[1];
        fall = st_ff.sclk_q && !st_ff.sclk_s[1];
        cs_rise = !st_ff.cs_q && st_ff.cs_s[1];
        tgt = (st_ff.cnt == 6'h20) ? st_ff.sh : st_ff.addr;
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sclk_s = {st_ff.sclk_s[0], link.sclk};
        nxt_st.sclk_q = st_ff.sclk_s[1];
        nxt_st.cs_s = {st_ff.cs_s[0], link.cs_n};
        nxt_st.cs_q = st_ff.cs_s[1];
        nxt_st.si_s = {st_ff.si_s[0], link.io[0]};
        nxt_st.wp_s = {st_ff.wp_s[0], link.io[2]};

        // self-timed cycle end clears busy and the latch
        if (st_ff.busy) begin
            if (st_ff.tmr == 16'h0000) begin
                nxt_st.busy = 1'b0;
                nxt_st.write_enable_latch = 1'b0;
            end else begin
                nxt_st.tmr = st_ff.tmr - 16'h0001;
            end
        end

        if (st_ff.cs_s[1]) begin
            nxt_st.cnt = 6'h00;
            nxt_st.so_en = 1'b0;
        end else begin
            if (rise) begin
                if (st_ff.cnt < 6'h08) begin
                    nxt_st.opc = {st_ff.opc[6:0], st_ff.si_s[1]};
                end else begin
                    nxt_st.sh = {st_ff.sh[22:0], st_ff.si_s[1]};
                end
                if (st_ff.cnt == 6'h20) begin
                    nxt_st.addr = st_ff.sh;
                end
                nxt_st.cnt = sat_inc(st_ff.cnt);
            end
            // reads stream on io1 only; io2/io3 play no part
            if (fall && st_ff.cnt >= 6'h08) begin
                if (st_ff.opc == OP_READ_STATUS) begin
                    nxt_st.so = status_byte[3'h7 - st_ff.cnt[2:0]];
                    nxt_st.so_en = 1'b1;
                end else if (st_ff.opc == READ_CONFIG_OP) begin
                    nxt_st.so = config_byte[3'h7 - st_ff.cnt[2:0]];
                    nxt_st.so_en = 1'b1;
                end
            end
        end

        // commands act on the chip-select rising edge
        if (cs_rise && !st_ff.busy) begin
            if (st_ff.opc == OP_WRITE_ENABLE && st_ff.cnt == 6'h08) begin
                nxt_st.write_enable_latch = 1'b1;
            end else if (st_ff.opc == OP_WRITE_STATUS && (st_ff.cnt == 6'h10 || st_ff.cnt == 6'h18)) begin
                // needs the latch; refused in hardware protection; bits 1,0 untouched
                if (st_ff.write_enable_latch && !hardware_protected_mode) begin
                    if (st_ff.cnt == 6'h10) begin
                        nxt_st.status_write_disable_bit = st_ff.sh[ST_STATUS_WRITE_DISABLE_BIT];
                        nxt_st.qe = st_ff.sh[ST_QE];
                        nxt_st.bp = st_ff.sh[ST_BP_LO +: 4];
                    end else begin
                        nxt_st.status_write_disable_bit = st_ff.sh[8 + ST_STATUS_WRITE_DISABLE_BIT];
                        nxt_st.qe = st_ff.sh[8 + ST_QE];
                        nxt_st.bp = st_ff.sh[8 + ST_BP_LO +: 4];
                        nxt_st.output_strength_select = st_ff.sh[CF_ODS];
                        nxt_st.dc = st_ff.sh[CF_DC];
                        nxt_st.tb = st_ff.tb | st_ff.sh[CF_TB];
                    end
                    nxt_st.busy = 1'b1;
                    nxt_st.tmr = TW_LOAD;
                end
            end else if (st_ff.opc == CHIP_ERASE_OP && st_ff.cnt == 6'h08 && st_ff.write_enable_latch) begin
                if (st_ff.bp == 4'h0) begin
                    nxt_st.busy = 1'b1;
                    nxt_st.tmr = PE_LOAD;
                end else begin
                    nxt_st.write_enable_latch = 1'b0;
                end
            end else if (st_ff.write_enable_latch && st_ff.cnt[2:0] == 3'h0 &&
                         (((st_ff.opc == SECTOR_ERASE_OP || st_ff.opc == BLOCK_ERASE_OP) && st_ff.cnt == 6'h20) ||
                          (st_ff.opc == PAGE_PROGRAM_OP && st_ff.cnt >= 6'h28))) begin
                if (in_protected(tgt, st_ff.bp, st_ff.tb)) begin
                    nxt_st.write_enable_latch = 1'b0;
                end else begin
                    nxt_st.busy = 1'b1;
                    nxt_st.tmr = PE_LOAD;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.sclk_s <= 2'b00;
            st_ff.cs_s <= 2'b11;
            st_ff.cs_q <= 1'b1;
            st_ff.wp_s <= 2'b11;
            st_ff.bp <= RST_BP;
            st_ff.qe <= RST_QE;
            st_ff.status_write_disable_bit <= RST_STATUS_WRITE_DISABLE_BIT;
            st_ff.output_strength_select <= RST_ODS;
            st_ff.tb <= RST_TB;
            st_ff.dc <= RST_DC;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link.d_io_o = {2'b11, st_ff.so, 1'b0};
    assign link.d_io_oe_n = {2'b11, ~st_ff.so_en, 1'b1};
    assign busy_o = st_ff.busy;
    assign status_o = status_byte;
    assign config_o = config_byte;
    assign quad_mode_o = st_ff.qe;
    assign hw_protect_o = hardware_protected_mode;
    assign quarter_strength_o = st_ff.output_strength_select;
    assign dual_dummy_o = st_ff.dc ? DUAL_DUMMY_1 : DUAL_DUMMY_0;
    assign quad_dummy_o = st_ff.dc ? QUAD_DUMMY_1 : QUAD_DUMMY_0;
endmodule // sfp_flash_dev

// [src/sfp_host_ctrl.sv]
`timescale 1ns/10ps
module sfp_host_ctrl #(
    parameter int HALF_DIV = sfp_pkg::SCLK_HALF_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    sfp_link_if.host link
);
    import sfp_pkg::*;

    // a read bit needs five clocks to come back through both synchronisers
    if (HALF_DIV < 6 || HALF_DIV > 255) begin : g_bad_div
        $error("sfp_host_ctrl: HALF_DIV must be 6..255");
    end

    typedef struct packed {
        sfp_host_state_t state;
        logic [7:0] div;
        logic sclk;
        logic cs_n;
        logic [39:0] tx;
        logic [5:0] left;
        logic [7:0] rx;
        logic [1:0] so_s;
        logic [31:0] txdata;
        logic wp;
        logic hold;
        logic ack;
        logic [31:0] rdat;
    } sfp_host_st_t;

    sfp_host_st_t st_ff;
    sfp_host_st_t nxt_st;
    logic tick;
    logic req;
    logic [5:0] nbits;

    localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);

    always_comb begin
        nxt_st = st_ff;
        tick = (st_ff.div == DIV_LAST);
        req = wb_cyc_i && wb_stb_i && !st_ff.ack;
        nbits = {wb_dat_i[CMD_NTX_LO +: 3], 3'b000} + {2'b00, wb_dat_i[CMD_RX], 3'b000} + 6'h08;
        nxt_st.so_s = {st_ff.so_s[0], link.io[1]};
        nxt_st.div = tick ? 8'h00 : st_ff.div + 8'h01;
        nxt_st.ack = req;

        case (st_ff.state)
            SFP_IDLE: begin
                nxt_st.div = 8'h00;
            end
            SFP_RUN: begin
                if (tick) begin
                    if (!st_ff.sclk) begin
                        nxt_st.sclk = 1'b1;
                        nxt_st.rx = {st_ff.rx[6:0], st_ff.so_s[1]};
                        nxt_st.left = st_ff.left - 6'h01;
                    end else begin
                        nxt_st.sclk = 1'b0;
                        nxt_st.tx = {st_ff.tx[38:0], 1'b0};
                        if (st_ff.left == 6'h00) begin
                            nxt_st.state = SFP_END;
                        end
                    end
                end
            end
            SFP_END: begin
                if (tick) begin
                    nxt_st.cs_n = 1'b1;
                    nxt_st.state = SFP_IDLE;
                end
            end
            default: begin
                nxt_st.state = SFP_IDLE;
            end
        endcase

        if (req && wb_we_i) begin
            case (wb_adr_i)
                REG_CMD: begin
                    if (st_ff.state == SFP_IDLE && wb_sel_i[0]) begin
                        nxt_st.state = SFP_RUN;
                        nxt_st.cs_n = 1'b0;
                        nxt_st.sclk = 1'b0;
                        nxt_st.tx = {wb_dat_i[7:0], st_ff.txdata};
                        nxt_st.left = nbits;
                        nxt_st.div = 8'h00;
                    end
                end
                REG_TXDATA: begin
                    for (int i = 0; i < 4; i++) begin
                        if (wb_sel_i[i]) begin
                            nxt_st.txdata[i*8 +: 8] = wb_dat_i[i*8 +: 8];
                        end
                    end
                end
                REG_PINS: begin
                    if (wb_sel_i[0]) begin
                        nxt_st.wp = wb_dat_i[0];
                        nxt_st.hold = wb_dat_i[1];
                    end
                end
                default: begin
                end
            endcase
        end

        nxt_st.rdat = 32'h0000_0000;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                REG_TXDATA: nxt_st.rdat = st_ff.txdata;
                REG_STAT: nxt_st.rdat = {16'h0000, st_ff.rx, 7'h00, st_ff.state != SFP_IDLE};
                REG_PINS: nxt_st.rdat = {30'h0, st_ff.hold, st_ff.wp};
                default: nxt_st.rdat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.state <= SFP_IDLE;
            st_ff.cs_n <= 1'b1;
            st_ff.wp <= 1'b1;
            st_ff.hold <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link.sclk = st_ff.sclk;
    assign link.cs_n = st_ff.cs_n;
    assign link.h_io_o = {st_ff.hold, st_ff.wp, 1'b0, st_ff.tx[39]};
    assign link.h_io_oe_n = 4'b0010;
    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = st_ff.rdat;
endmodule // sfp_host_ctrl

// [tb/sfp_link_properties.sv]
`timescale 1ns/10ps
module sfp_link_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] h_io_o,
    input wire logic [3:0] h_io_oe_n,
    input wire logic [3:0] d_io_o,
    input wire logic [3:0] d_io_oe_n,
    input wire logic [3:0] io
);
    logic [5:0] bit_cnt_ff;
    // counts serial clock rises inside the current frame
    always_ff @(posedge clk_i) begin
        if (rst_i || $fell(cs_n)) begin
            bit_cnt_ff <= 6'h00;
        end else if (!cs_n && $rose(sclk)) begin
            bit_cnt_ff <= bit_cnt_ff + 6'h01;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_frame_end;
        $rose(cs_n);
    endsequence
    sequence s_clock_high;
        sclk && $past(sclk);
    endsequence
    property p_idle_clock; cs_n |-> !sclk; endproperty
    property p_read_start; $fell(d_io_oe_n[1]) |-> bit_cnt_ff == 6'h08; endproperty
    property p_dev_quiet; s_frame_end |-> ##[1:3] (d_io_oe_n[1] && io[1]); endproperty
    property p_dev_release; cs_n [*6] |-> d_io_oe_n[1]; endproperty
    property p_clock_hold; $changed(sclk) |=> $stable(sclk) [*3]; endproperty
    property p_mosi_change; $changed(h_io_o[0]) |-> !sclk; endproperty
    property p_miso_hold; s_clock_high and !d_io_oe_n[1] |-> $stable(d_io_o[1]); endproperty
    property p_byte_end; s_frame_end |-> bit_cnt_ff[2:0] == 3'h0 && bit_cnt_ff[5:3] != 3'h0; endproperty
    property p_end_gap; s_frame_end |-> !$past(sclk, 3); endproperty
    a_idle_clock: assert property (p_idle_clock)
        else $error("serial clock high outside frame");
    a_read_start: assert property (p_read_start)
        else $error("device began driving io1 off the opcode boundary");
    a_dev_quiet: assert property (p_dev_quiet)
        else $error("io1 not released soon after frame end");
    a_dev_release: assert property (p_dev_release)
        else $error("device drives io1 outside frame");
    a_clock_hold: assert property (p_clock_hold)
        else $error("serial clock phase too short");
    a_mosi_change: assert property (p_mosi_change)
        else $error("host data moved while clock high");
    a_miso_hold: assert property (p_miso_hold)
        else $error("read data moved while clock high");
    a_byte_end: assert property (p_byte_end)
        else $error("frame ended off a byte boundary");
    a_end_gap: assert property (p_end_gap)
        else $error("chip select rose too soon after clock");
endmodule // sfp_link_properties

// [tb/serial_flash_status_config_protect_test.sv]
`timescale 1ns/10ps
module serial_flash_status_config_protect_test;
    import sfp_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [3:0] sel = 4'hF;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic [31:0] rdat;
    logic ack;
    logic busy, qmode, hwp, qstr;
    logic [7:0] stat, conf;
    logic [3:0] ddum, qdum;
    logic [7:0] mosi_sh = 8'h00;
    logic [7:0] mosi_last = 8'h00;
    logic sclk_q = 1'b0;
    logic [31:0] q;
    logic [7:0] b;
    int checks = 0;
    int err_total = 0;
    sfp_link_if link();
    sfp_host_ctrl #(.HALF_DIV(8)) sfp_host_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
        .link(link));
    sfp_flash_dev #(.TW_CYCLES(1000), .PE_CYCLES(1000)) sfp_flash_dev_i (.clk_i(clk_i), .rst_i(rst_i),
        .link(link), .busy_o(busy), .status_o(stat), .config_o(conf), .quad_mode_o(qmode),
        .hw_protect_o(hwp), .quarter_strength_o(qstr), .dual_dummy_o(ddum), .quad_dummy_o(qdum));
    sfp_link_properties sfp_link_properties_i (.clk_i(clk_i), .rst_i(rst_i), .sclk(link.sclk), .cs_n(link.cs_n),
        .h_io_o(link.h_io_o), .h_io_oe_n(link.h_io_oe_n), .d_io_o(link.d_io_o), .d_io_oe_n(link.d_io_oe_n),
        .io(link.io));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // collects the last byte the host shifted out on io0
    always @(posedge clk_i) begin
        sclk_q <= link.sclk;
        if (!link.cs_n && link.sclk && !sclk_q) begin
            mosi_sh <= {mosi_sh[6:0], link.io[0]};
        end
        if (link.cs_n) begin
            mosi_last <= mosi_sh;
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hang();
        err_total++;
        $display("unexpected at %0t: wait ran out", $time);
        give_verdict();
    endtask
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk_i);
        adr <= a;
        we <= w;
        dat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) hang();
    endtask
    task automatic frame(input logic [7:0] op, input logic [2:0] ntx, input logic rx, input logic [31:0] tx,
        output logic [7:0] rb);
        logic [31:0] r;
        int n;
        wb(REG_TXDATA, 1'b1, tx, r);
        wb(REG_CMD, 1'b1, {20'h0, rx, ntx, op}, r);
        n = 0;
        do begin
            wb(REG_STAT, 1'b0, 32'h0, r);
            n++;
        end while (r[0] !== 1'b0 && n < 400);
        if (r[0] !== 1'b0) hang();
        rb = r[15:8];
        // the device acts a few clocks after chip select rises
        repeat (8) @(posedge clk_i);
    endtask
    task automatic rdst(output logic [7:0] rb);
        frame(OP_READ_STATUS, 3'h0, 1'b1, 32'h0, rb);
    endtask
    task automatic write_enable_cmd();
        logic [7:0] x;
        frame(OP_WRITE_ENABLE, 3'h0, 1'b0, 32'h0, x);
    endtask
    task automatic wait_idle(output logic [7:0] rb);
        int n;
        n = 0;
        do begin
            rdst(rb);
            n++;
        end while (rb[0] !== 1'b0 && n < 100);
        if (rb[0] !== 1'b0) hang();
    endtask
    task automatic pins(input logic [31:0] v);
        logic [31:0] r;
        wb(REG_PINS, 1'b1, v, r);
        repeat (6) @(posedge clk_i);
    endtask
    // unprotected erase: busy with latch set, then both clear at completion
    task automatic erase_run(input logic [7:0] op, input logic [2:0] ntx);
        logic [7:0] rb;
        write_enable_cmd();
        frame(op, ntx, 1'b0, 32'h0, rb);
        rdst(rb);
        chk(rb[1:0], 32'h3);
        chk(busy, 32'h1);
        wait_idle(rb);
        chk(rb, 8'hC0);
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(stat, 32'h0);
        chk(busy, 32'h0);
        chk(conf, 32'h0);
        chk(ddum, DUAL_DUMMY_0);
        chk(qdum, QUAD_DUMMY_0);
        wb(4'h2, 1'b0, 32'h0, q);
        chk(q, 32'h0);
        wb(REG_PINS, 1'b0, 32'h0, q);
        chk(q, 32'h3);
        rdst(b);
        chk(b, 8'h00);
        $display("test reset done");
        frame(OP_WRITE_STATUS, 3'h2, 1'b0, 32'h3C410000, b);
        chk(stat, 32'h0);
        write_enable_cmd();
        chk(mosi_last, 8'h06);
        rdst(b);
        chk(b, 8'h02);
        frame(OP_WRITE_STATUS, 3'h2, 1'b0, 32'hBF490000, b);
        rdst(b);
        chk(b, 8'hBF);
        frame(8'hA5, 3'h0, 1'b1, 32'h0, b);
        chk(b, 8'h49);
        wait_idle(b);
        chk(b, 8'hBC);
        chk(qstr, 32'h1);
        chk(ddum, DUAL_DUMMY_1);
        chk(qdum, QUAD_DUMMY_1);
        $display("test status write done");
        write_enable_cmd();
        frame(8'hC7, 3'h0, 1'b0, 32'h0, b);
        rdst(b);
        chk(b, 8'hBC);
        frame(8'h02, 3'h4, 1'b0, 32'h0, b);
        rdst(b);
        chk(b, 8'hBC);
        $display("test guarded erase done");
        pins(32'h2);
        chk(hwp, 32'h1);
        write_enable_cmd();
        frame(OP_WRITE_STATUS, 3'h2, 1'b0, 32'h0, b);
        rdst(b);
        chk(b, 8'hBE);
        chk(conf[3], 32'h1);
        // program into the guarded bottom area: refused, latch cleared, no busy
        frame(8'h02, 3'h4, 1'b0, 32'h0, b);
        rdst(b);
        chk(b, 8'hBC);
        pins(32'h3);
        chk(hwp, 32'h0);
        $display("test hardware protect done");
        write_enable_cmd();
        frame(OP_WRITE_STATUS, 3'h3, 1'b0, 32'h0, b);
        rdst(b);
        chk(b, 8'hBE);
        frame(OP_WRITE_STATUS, 3'h2, 1'b0, 32'hC0000000, b);
        wait_idle(b);
        chk(b, 8'hC0);
        chk(conf, 32'h08);
        chk(qmode, 32'h1);
        pins(32'h2);
        chk(hwp, 32'h0);
        $display("test quad and boundary done");
        erase_run(8'hC7, 3'h0);
        erase_run(8'h20, 3'h3);
        erase_run(8'hD8, 3'h3);
        $display("test erase done");
        give_verdict();
    end
endmodule // serial_flash_status_config_protect_test
